// >>> rtl/ccw_cfg.svh
// Purpose: Constants for the call, clear and watchdog-clear execute block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Widths, depths and reset values live here; types live in the
//   package.
// Function
// [RULE1] Call jumps unconditionally to its target.
// [RULE2] Call pushes program counter plus one.
// [RULE3] Program counter loads target, fetch continues there.
// [RULE4] Call takes two cycles, second fetches nothing.
// [RULE5] Clear byte writes zero, flags unchanged.
// [RULE6] Clear bit zeroes one bit only.
// [RULE7] Single clear restarts watchdog, clears both flags.
// [RULE8] First pre-clear acts only alternated with second.
// [RULE9] Repeated first pre-clear has no effect.
// [RULE10] Second pre-clear acts only alternated with first.
// [RULE11] Repeated second pre-clear has no effect.
// [RULE12] Pair clears flags only when run consecutively; the code also pairs two halves that have other ops between them.
// [RULE13] Pair record resets so pairing restarts fresh.
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH

`define CCW_PC_W 11
`define CCW_PC_STEP 11'h001
`define CCW_PC_RST 11'h000
`define CCW_ADDR_W 7
`define CCW_MEM_DEPTH 128
`define CCW_DATA_W 8
`define CCW_BYTE_CLR 8'h00
`define CCW_BIT_W 3
`define CCW_STACK_DEPTH 4
`define CCW_SP_W 2
`define CCW_LVL_W 3
`define CCW_LVL_MAX 3'h4
`define CCW_FLAG_RST 1'b0
`define CCW_HALF_FIRST 1'b0
`define CCW_HALF_SECOND 1'b1

`endif

// >>> rtl/ccw_pkg.sv
// Purpose: Types shared by the execute block and its testbench.
// Assumes: Constants come from ccw_cfg.svh.
// Notes: Opcode codes are internal decode results, not raw opcodes.
`default_nettype none

package ccw_pkg;

  // Decoded operation presented to the execute stage.
  typedef enum logic [2:0] {
    CCW_OP_NOP      = 3'h0,
    CCW_OP_CALL     = 3'h1,
    CCW_OP_CLR_BYTE = 3'h2,
    CCW_OP_CLR_BIT  = 3'h3,
    CCW_OP_WD_CLR   = 3'h4,
    CCW_OP_WD_PRE1  = 3'h5,
    CCW_OP_WD_PRE2  = 3'h6
  } ccw_op_t;

  // Execute sequencer: normal issue or the second call cycle.
  typedef enum logic [0:0] {
    CCW_ST_ISSUE = 1'b0,
    CCW_ST_CALL2 = 1'b1
  } ccw_state_t;

endpackage

`default_nettype wire

// >>> rtl/ccw_stack.sv
// Purpose: Return-address stack, push side only.
// Assumes: Pops are handled elsewhere; overflow wraps onto oldest entry.
// Notes: Level saturates at full depth.
`include "ccw_cfg.svh"
`default_nettype none

module ccw_stack (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  // Push request.
  input wire logic push_i,
  input wire logic [`CCW_PC_W-1:0] push_data_i,
  // State.
  output logic [`CCW_PC_W-1:0] top_o,
  output logic [`CCW_LVL_W-1:0] level_o
);

  logic [`CCW_PC_W-1:0] entry [`CCW_STACK_DEPTH];
  logic [`CCW_PC_W-1:0] next_entry [`CCW_STACK_DEPTH];
  logic [`CCW_SP_W-1:0] sp, next_sp;
  logic [`CCW_PC_W-1:0] next_top;
  logic [`CCW_LVL_W-1:0] next_level;

  // Push writes the slot at the pointer and copies the value to the top.
  always_comb begin
    next_entry = entry;
    next_sp = sp;
    next_top = top_o;
    next_level = level_o;
    if (en_i && push_i) begin
      next_entry[sp] = push_data_i;
      next_sp = sp + 2'h1;
      next_top = push_data_i;
      if (level_o != `CCW_LVL_MAX) begin
        next_level = level_o + 3'h1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `CCW_STACK_DEPTH; i++) begin
        entry[i] <= `CCW_PC_RST;
      end
      sp <= 2'h0;
      top_o <= `CCW_PC_RST;
      level_o <= 3'h0;
    end else begin
      entry <= next_entry;
      sp <= next_sp;
      top_o <= next_top;
      level_o <= next_level;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/ccw_preclr.sv
// Purpose: Pairing logic for the two watchdog pre-clear halves.
// Assumes: At most one half is presented per enabled cycle.
// Notes: clear_o is combinational; the caller registers its effect.
`include "ccw_cfg.svh"
`default_nettype none

module ccw_preclr (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  // Halves being executed this cycle.
  input wire logic first_i,
  input wire logic second_i,
  // Pair completed now.
  output logic clear_o
);

  logic armed, next_armed;
  logic half, next_half;

  // A half clears only when the other half was the last one seen.
  // After a completed pair the record disarms, so each pair is fresh.
  always_comb begin
    clear_o = armed && ((first_i && half == `CCW_HALF_SECOND) ||
                        (second_i && half == `CCW_HALF_FIRST)); // RULE8
    next_armed = armed;
    next_half = half;
    if (en_i && clear_o) begin
      next_armed = 1'b0;
    end else if (en_i && first_i) begin
      next_armed = 1'b1; // RULE9
      next_half = `CCW_HALF_FIRST;
    end else if (en_i && second_i) begin
      next_armed = 1'b1; // RULE11
      next_half = `CCW_HALF_SECOND;
    end
  end

  // Record starts disarmed out of reset.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      armed <= 1'b0; // RULE13
      half <= `CCW_HALF_FIRST;
    end else begin
      armed <= next_armed;
      half <= next_half;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/ccw_exec.sv
// Purpose: Execute stage for call, clear-memory and watchdog-clear.
// Assumes: Decoded ops arrive with valid; only taken while ready_o high.
// Notes: Data memory is flip-flops; rd_data_o shows the addressed byte
//   one cycle later, before any write of that same cycle.
`include "ccw_cfg.svh"
`default_nettype none

module ccw_exec
  import ccw_pkg::*;
(
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  // Instruction issue.
  input wire logic instr_valid_i,
  input wire ccw_op_t op_i,
  input wire logic [`CCW_PC_W-1:0] target_i,
  input wire logic [`CCW_ADDR_W-1:0] addr_i,
  input wire logic [`CCW_BIT_W-1:0] bit_i,
  // Plain byte store from the rest of the core.
  input wire logic load_i,
  input wire logic [`CCW_DATA_W-1:0] load_data_i,
  // Flag set events from watchdog time-out and power-down entry.
  input wire logic timeout_set_i,
  input wire logic powerdown_set_i,
  // Sequencer state.
  output logic ready_o,
  output logic [`CCW_PC_W-1:0] pc_o,
  // Stack view.
  output logic [`CCW_PC_W-1:0] stack_top_o,
  output logic [`CCW_LVL_W-1:0] stack_level_o,
  // Data memory view.
  output logic [`CCW_DATA_W-1:0] rd_data_o,
  // Status and watchdog.
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic wdog_restart_o
);

  ccw_state_t state, next_state;
  logic next_ready;
  logic [`CCW_PC_W-1:0] next_pc;
  logic take;
  logic is_call, is_cbyte, is_cbit, is_single, is_pre1, is_pre2;
  logic pair_clear, wd_clear;
  logic next_to, next_pd, next_restart;
  logic [`CCW_DATA_W-1:0] mem [`CCW_MEM_DEPTH];
  logic [`CCW_DATA_W-1:0] next_mem [`CCW_MEM_DEPTH];
  logic [`CCW_DATA_W-1:0] next_rd;

  // An op is taken only in the issue state while enabled.
  assign take = en_i && ready_o && instr_valid_i;
  assign is_call = take && op_i == CCW_OP_CALL;
  assign is_cbyte = take && op_i == CCW_OP_CLR_BYTE;
  assign is_cbit = take && op_i == CCW_OP_CLR_BIT;
  assign is_single = take && op_i == CCW_OP_WD_CLR;
  assign is_pre1 = take && op_i == CCW_OP_WD_PRE1;
  assign is_pre2 = take && op_i == CCW_OP_WD_PRE2;

  // Pre-clear pairing lives in its own small module.
  ccw_preclr u_preclr (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(en_i),
    .first_i(is_pre1),
    .second_i(is_pre2),
    .clear_o(pair_clear)
  );

  // The return address is the address after the call itself.
  ccw_stack u_stack (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(en_i),
    .push_i(is_call),
    .push_data_i(pc_o + `CCW_PC_STEP), // RULE2
    .top_o(stack_top_o),
    .level_o(stack_level_o)
  );

  // Sequencer and program counter. A call spends its second cycle with
  // ready low so no following op is taken while the jump settles.
  always_comb begin
    next_state = state;
    next_ready = ready_o;
    next_pc = pc_o;
    if (en_i) begin
      unique case (state)
        CCW_ST_ISSUE: begin
          if (is_call) begin
            next_pc = target_i; // RULE1 RULE3
            next_state = CCW_ST_CALL2; // RULE4
            next_ready = 1'b0;
          end else if (take) begin
            next_pc = pc_o + `CCW_PC_STEP;
          end
        end
        CCW_ST_CALL2: begin
          next_state = CCW_ST_ISSUE;
          next_ready = 1'b1;
        end
      endcase
    end
  end

  // Registers for the sequencer.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= CCW_ST_ISSUE;
      ready_o <= 1'b1;
      pc_o <= `CCW_PC_RST;
    end else begin
      state <= next_state;
      ready_o <= next_ready;
      pc_o <= next_pc;
    end
  end

  // Memory writes. A clear of the addressed byte outranks a plain
  // store in the same cycle, since the store belongs to another op.
  always_comb begin
    next_mem = mem;
    next_rd = rd_data_o;
    if (en_i) begin
      next_rd = mem[addr_i];
      if (is_cbyte) begin
        next_mem[addr_i] = `CCW_BYTE_CLR; // RULE5
      end else if (is_cbit) begin
        next_mem[addr_i][bit_i] = 1'b0; // RULE6
      end else if (load_i) begin
        next_mem[addr_i] = load_data_i;
      end
    end
  end

  // Registers for the data memory.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `CCW_MEM_DEPTH; i++) begin
        mem[i] <= `CCW_BYTE_CLR;
      end
      rd_data_o <= `CCW_BYTE_CLR;
    end else begin
      mem <= next_mem;
      rd_data_o <= next_rd;
    end
  end

  // Watchdog clears. A set event in the same cycle wins over the
  // clear, so a time-out is never lost to a racing clear.
  assign wd_clear = is_single || pair_clear; // RULE7 RULE10 RULE12
  always_comb begin
    next_to = timeout_flag_o;
    next_pd = powerdown_flag_o;
    next_restart = wdog_restart_o;
    if (en_i) begin
      next_restart = wd_clear;
      if (wd_clear) begin
        next_to = 1'b0;
        next_pd = 1'b0;
      end
      if (timeout_set_i) begin
        next_to = 1'b1;
      end
      if (powerdown_set_i) begin
        next_pd = 1'b1;
      end
    end
  end

  // Registers for the flags and the restart pulse.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timeout_flag_o <= `CCW_FLAG_RST;
      powerdown_flag_o <= `CCW_FLAG_RST;
      wdog_restart_o <= 1'b0;
    end else begin
      timeout_flag_o <= next_to;
      powerdown_flag_o <= next_pd;
      wdog_restart_o <= next_restart;
    end
  end

  // Helper capture for the memory checks below.
  logic [`CCW_ADDR_W-1:0] chk_addr;
  logic [`CCW_DATA_W-1:0] chk_old;
  logic [`CCW_DATA_W-1:0] chk_mask;
  always_ff @(posedge clk_i) begin
    chk_addr <= addr_i;
    chk_old <= mem[addr_i];
    chk_mask <= 8'h01 << bit_i;
  end

  // Which pre-clear half ran last since reset. It is kept apart from
  // the pairing module so the checks below do not lean on its record.
  logic pre_seen;
  logic pre_last_first;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_seen <= 1'b0;
      pre_last_first <= 1'b0;
    end else if (is_pre1 || is_pre2) begin
      pre_seen <= 1'b1;
      pre_last_first <= is_pre1;
    end
  end

  property p_call_jump;
    @(posedge clk_i) disable iff (reset_i)
      is_call |=> pc_o == $past(target_i);
  endproperty
  a_call_jump: assert property (p_call_jump) // RULE1
    else $error("Call did not load target.");

  property p_call_push;
    @(posedge clk_i) disable iff (reset_i)
      is_call |=> stack_top_o == $past(pc_o) + `CCW_PC_STEP;
  endproperty
  a_call_push: assert property (p_call_push) // RULE2
    else $error("Call pushed wrong return address.");

  property p_call_fetch;
    @(posedge clk_i) disable iff (reset_i)
      state == CCW_ST_CALL2 && en_i |=> ready_o && $stable(pc_o);
  endproperty
  a_call_fetch: assert property (p_call_fetch) // RULE3
    else $error("Call target not held for fetch.");

  property p_call_two;
    @(posedge clk_i) disable iff (reset_i)
      is_call |=> !ready_o;
  endproperty
  a_call_two: assert property (p_call_two) // RULE4
    else $error("Call did not stall second cycle.");

  property p_clr_byte;
    @(posedge clk_i) disable iff (reset_i)
      is_cbyte && !timeout_set_i && !powerdown_set_i |=>
        mem[chk_addr] == `CCW_BYTE_CLR && $stable(timeout_flag_o) &&
        $stable(powerdown_flag_o);
  endproperty
  a_clr_byte: assert property (p_clr_byte) // RULE5
    else $error("Clear byte failed.");

  property p_clr_bit;
    @(posedge clk_i) disable iff (reset_i)
      is_cbit |=> mem[chk_addr] == (chk_old & ~chk_mask);
  endproperty
  a_clr_bit: assert property (p_clr_bit) // RULE6
    else $error("Clear bit touched wrong bits.");

  property p_single;
    @(posedge clk_i) disable iff (reset_i)
      is_single && !timeout_set_i && !powerdown_set_i |=>
        wdog_restart_o && !timeout_flag_o && !powerdown_flag_o;
  endproperty
  a_single: assert property (p_single) // RULE7
    else $error("Single clear did not act.");

  // Back-to-back halves must clear. A first half that itself closed an
  // earlier pair shows as a restart pulse and leaves nothing armed.
  property p_pair;
    @(posedge clk_i) disable iff (reset_i)
      is_pre1 ##1 (is_pre2 && !wdog_restart_o && !timeout_set_i &&
        !powerdown_set_i) |=>
        wdog_restart_o && !timeout_flag_o && !powerdown_flag_o;
  endproperty
  a_pair: assert property (p_pair) // RULE8 RULE12
    else $error("Alternated pre-clear did not act.");

  // The reverse order pairs as well.
  property p_pair_rev;
    @(posedge clk_i) disable iff (reset_i)
      is_pre2 ##1 (is_pre1 && !wdog_restart_o && !timeout_set_i &&
        !powerdown_set_i) |=>
        wdog_restart_o && !timeout_flag_o && !powerdown_flag_o;
  endproperty
  a_pair_rev: assert property (p_pair_rev) // RULE10
    else $error("Reverse pre-clear pair did not act.");

  property p_repeat1;
    @(posedge clk_i) disable iff (reset_i)
      is_pre1 && pre_seen && pre_last_first |=> !wdog_restart_o;
  endproperty
  a_repeat1: assert property (p_repeat1) // RULE9
    else $error("Repeated first pre-clear acted.");

  property p_repeat2;
    @(posedge clk_i) disable iff (reset_i)
      is_pre2 && pre_seen && !pre_last_first |=> !wdog_restart_o;
  endproperty
  a_repeat2: assert property (p_repeat2) // RULE11
    else $error("Repeated second pre-clear acted.");

  // The first half of either kind after reset never clears alone.
  property p_first_after_reset;
    @(posedge clk_i) disable iff (reset_i)
      (is_pre1 || is_pre2) && !pre_seen |=> !wdog_restart_o;
  endproperty
  a_first_after_reset: assert property (p_first_after_reset) // RULE13
    else $error("Pre-clear acted alone after reset.");

  property p_flags_hold;
    @(posedge clk_i) disable iff (reset_i)
      en_i && !wd_clear && !timeout_set_i && !powerdown_set_i |=>
        $stable(timeout_flag_o) && $stable(powerdown_flag_o);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // RULE12
    else $error("Flags changed without cause.");

endmodule

`default_nettype wire

// >>> dv/ccw_exec_tb.sv
// Purpose: Self-checking bench for the call, clear and watchdog-clear stage.
// Assumes: Inputs change on the falling edge; outputs are read there too.
// Notes: Expected values come from the instruction behaviour only, never
//   from the design's outputs.
`include "ccw_cfg.svh"
`default_nettype none

module ccw_exec_tb
  import ccw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals.
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic en_i = 1'b1;
  logic instr_valid_i = 1'b0;
  ccw_op_t op_i = CCW_OP_NOP;
  logic [`CCW_PC_W-1:0] target_i = 11'h000;
  logic [`CCW_ADDR_W-1:0] addr_i = 7'h00;
  logic [`CCW_BIT_W-1:0] bit_i = 3'h0;
  logic load_i = 1'b0;
  logic [`CCW_DATA_W-1:0] load_data_i = 8'h00;
  logic timeout_set_i = 1'b0;
  logic powerdown_set_i = 1'b0;
  logic ready_o;
  logic [`CCW_PC_W-1:0] pc_o;
  logic [`CCW_PC_W-1:0] stack_top_o;
  logic [`CCW_LVL_W-1:0] stack_level_o;
  logic [`CCW_DATA_W-1:0] rd_data_o;
  logic timeout_flag_o;
  logic powerdown_flag_o;
  logic wdog_restart_o;
  int miscompares = 0;
  int compares = 0;

  // Clock at 125 MHz.
  always #4 clk_i = ~clk_i;

  ccw_exec u_ccw_exec (
    .clk_i(clk_i), .reset_i(reset_i), .en_i(en_i),
    .instr_valid_i(instr_valid_i), .op_i(op_i), .target_i(target_i),
    .addr_i(addr_i), .bit_i(bit_i), .load_i(load_i),
    .load_data_i(load_data_i), .timeout_set_i(timeout_set_i),
    .powerdown_set_i(powerdown_set_i), .ready_o(ready_o), .pc_o(pc_o),
    .stack_top_o(stack_top_o), .stack_level_o(stack_level_o),
    .rd_data_o(rd_data_o), .timeout_flag_o(timeout_flag_o),
    .powerdown_flag_o(powerdown_flag_o), .wdog_restart_o(wdog_restart_o)
  );

  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one observed value; the wide argument keeps unknowns visible.
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Drives every input but en_i and reset_i once, then waits one full cycle to the next
  // falling edge, so no signal is ever assigned twice in one step.
  task automatic drv(input logic v, input ccw_op_t op,
                     input logic [10:0] t, input logic [6:0] a,
                     input logic [2:0] b, input logic ld,
                     input logic [7:0] d, input logic fs);
    instr_valid_i = v;
    op_i = op;
    target_i = t;
    addr_i = a;
    bit_i = b;
    load_i = ld;
    load_data_i = d;
    timeout_set_i = fs;
    powerdown_set_i = fs;
    @(negedge clk_i);
  endtask

  // Shorthands for an issued op and a flag-set cycle.
  task automatic op(input ccw_op_t o);
    drv(1'b1, o, 11'h000, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0);
  endtask

  task automatic set_flags();
    drv(1'b0, CCW_OP_NOP, 11'h000, 7'h00, 3'h0, 1'b0, 8'h00, 1'b1);
  endtask

  // Checks the restart pulse and both flags together.
  task automatic chk_wd(input logic r, input logic f);
    chk("restart", {31'h0, r}, {31'h0, wdog_restart_o});
    chk("timeout", {31'h0, f}, {31'h0, timeout_flag_o});
    chk("powerdown", {31'h0, f}, {31'h0, powerdown_flag_o});
  endtask

  task automatic do_reset();
    reset_i = 1'b1;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
  endtask

  // Call from a known address, a refused op in the dead cycle, then a
  // second call one op after the stage is ready again.
  task automatic t_call();
    repeat (3) op(CCW_OP_NOP);
    chk("pc", 32'h3, {21'h0, pc_o});
    en_i = 1'b0;
    drv(1'b1, CCW_OP_CALL, 11'h222, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("pc frozen", 32'h3, {21'h0, pc_o});
    en_i = 1'b1;
    drv(1'b1, CCW_OP_CALL, 11'h5a3, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("pc", 32'h5a3, {21'h0, pc_o});
    chk("stack top", 32'h4, {21'h0, stack_top_o});
    chk("level", 32'h1, {29'h0, stack_level_o});
    chk("ready", 32'h0, {31'h0, ready_o});
    drv(1'b1, CCW_OP_CALL, 11'h111, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("pc", 32'h5a3, {21'h0, pc_o});
    chk("level", 32'h1, {29'h0, stack_level_o});
    chk("ready", 32'h1, {31'h0, ready_o});
    op(CCW_OP_NOP);
    chk("pc", 32'h5a4, {21'h0, pc_o});
    drv(1'b1, CCW_OP_CALL, 11'h7ff, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("pc", 32'h7ff, {21'h0, pc_o});
    chk("stack top", 32'h5a5, {21'h0, stack_top_o});
    chk("level", 32'h2, {29'h0, stack_level_o});
    op(CCW_OP_NOP);
  endtask

  // Byte clear with both flags set: the byte goes to zero, flags stay.
  task automatic t_clr_byte();
    drv(1'b0, CCW_OP_NOP, 11'h000, 7'h7f, 3'h0, 1'b1, 8'hff, 1'b1);
    drv(1'b1, CCW_OP_CLR_BYTE, 11'h000, 7'h7f, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("timeout kept", 32'h1, {31'h0, timeout_flag_o});
    chk("powerdown kept", 32'h1, {31'h0, powerdown_flag_o});
    drv(1'b0, CCW_OP_NOP, 11'h000, 7'h7f, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("byte", 32'h0, {24'h0, rd_data_o});
  endtask

  // Every bit position once; the other seven bits must survive.
  task automatic t_clr_bit();
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      e = ~(8'h01 << b);
      drv(1'b0, CCW_OP_NOP, 11'h000, 7'(b), 3'h0, 1'b1, 8'hff, 1'b0);
      drv(1'b1, CCW_OP_CLR_BIT, 11'h000, 7'(b), 3'(b), 1'b0, 8'h00, 1'b0);
      drv(1'b0, CCW_OP_NOP, 11'h000, 7'(b), 3'h0, 1'b0, 8'h00, 1'b0);
      chk("bit clear", {24'h0, e}, {24'h0, rd_data_o});
    end
  endtask

  // Single clear: one restart pulse and both flags low.
  task automatic t_single();
    set_flags();
    op(CCW_OP_WD_CLR);
    chk_wd(1'b1, 1'b0);
    op(CCW_OP_NOP);
    chk_wd(1'b0, 1'b0);
    drv(1'b1, CCW_OP_WD_CLR, 11'h000, 7'h00, 3'h0, 1'b0, 8'h00, 1'b1);
    chk_wd(1'b1, 1'b1);
  endtask

  // Pre-clear pairs in both orders, with repeats that must do nothing.
  task automatic t_pair();
    set_flags();
    op(CCW_OP_WD_PRE1);
    chk_wd(1'b0, 1'b1);
    op(CCW_OP_WD_PRE2);
    chk_wd(1'b1, 1'b0);
    set_flags();
    op(CCW_OP_WD_PRE1);
    op(CCW_OP_WD_PRE1);
    chk_wd(1'b0, 1'b1);
    op(CCW_OP_NOP);
    op(CCW_OP_WD_PRE2);
    chk_wd(1'b1, 1'b0);
    set_flags();
    op(CCW_OP_WD_PRE2);
    op(CCW_OP_WD_PRE2);
    chk_wd(1'b0, 1'b1);
    op(CCW_OP_WD_PRE1);
    chk_wd(1'b1, 1'b0);
  endtask

  // A half armed before reset must not complete a pair after it.
  task automatic t_reset_pair();
    op(CCW_OP_WD_PRE1);
    do_reset();
    chk("pc", 32'h0, {21'h0, pc_o});
    chk("ready", 32'h1, {31'h0, ready_o});
    set_flags();
    op(CCW_OP_WD_PRE2);
    chk_wd(1'b0, 1'b1);
    op(CCW_OP_WD_PRE1);
    chk_wd(1'b1, 1'b0);
  endtask

  // Main sequence.
  initial begin
    do_reset();
    t_call();
    t_clr_byte();
    t_clr_bit();
    t_single();
    t_pair();
    t_reset_pair();
    final_report();
  end

  // Watchdog: the tests need well under a few hundred cycles.
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    $display("Error watchdog expected finish seen hang");
    final_report();
  end

endmodule

`default_nettype wire
